// ==== dv/flash_model.sv ====
// flash array stand-in: word memory, ack after a short or stretched delay
// assumes the engine holds each request until its ack
`timescale 1ns/1ps
module flash_model (
   input  wire logic                  clk,
   input  wire logic                  slow,  // stretch the ack delay
   input  wire logic                  fail,  // answer with error, change nothing
   input  wire store_pkg::flash_req_t req,
   output store_pkg::flash_rsp_t      rsp
);
   logic [31:0] mem [0:42];  // data, checksum, count, marker
   int          cnt;         // cycles the request has waited
   initial begin
      foreach (mem[i]) mem[i] = store_pkg::ERASED_WORD;  // blank part reads all ones
      cnt = 0;
      rsp = '0;
   end
   // data line toggles while not answering, so stale data cannot pass
   always @(posedge clk) begin
      rsp <= '{1'b0, 1'b0, ~rsp.rdata};
      if (req.valid && !rsp.ack) begin
         if (cnt < (slow ? 3 : 0)) cnt <= cnt + 1;
         else begin
            cnt <= 0;
            rsp.ack <= 1'b1;
            rsp.err <= fail;
            if (req.op == store_pkg::FOP_READ) rsp.rdata <= mem[req.addr];
            else if (!fail && req.op == store_pkg::FOP_WRITE) mem[req.addr] <= req.wdata;
            else if (!fail) foreach (mem[i]) mem[i] <= store_pkg::ERASED_WORD;
         end
      end
   end
endmodule : flash_model

// ==== dv/store_monitor.sv ====
// checker: engine busy timing, flash requests and bus answers
// assumes a bind onto persistent_variable_store, one clock domain
`timescale 1ns/1ps
module store_monitor #(
   parameter int COMMIT_CYC = 600,  // shortened commit limit
   parameter int ERASE_CYC  = 50    // shortened erase time
) (
   input wire logic                  pclk, presetn, psel, penable, pwrite,
   input wire logic                  pready, pslverr, irq,
   input wire logic [11:0]           paddr,
   input wire logic [31:0]           pwdata, prdata,
   input wire logic [3:0]            pstrb,
   input wire store_pkg::flash_req_t fl_req,
   input wire store_pkg::flash_rsp_t fl_rsp
);
   localparam int ELO = ERASE_CYC;       // busy span of an erase
   localparam int EHI = ERASE_CYC + 2;   // slack for take and return edges
   localparam int CHI = COMMIT_CYC + 2;  // commit limit plus the same slack
   logic tk, cc, ce;                     // transfer taken, commit, erase
   assign tk = psel && penable && pready;
   assign cc = tk && pwrite && paddr == store_pkg::OFF_CMD && pwdata[0];
   assign ce = tk && pwrite && paddr == store_pkg::OFF_CMD && pwdata[1:0] == 2'b10;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_cmd_blocks: assert property (cc || ce |=> !pready)
      else $error("bus served during flash work");
   a_commit_bound: assert property (cc |-> ##[2:CHI] $rose(pready))
      else $error("commit overran its limit");
   a_erase_time: assert property (ce |-> ##[ELO:EHI] $rose(pready))
      else $error("erase span wrong");
   a_erase_issue: assert property (ce |-> ##[1:3] fl_req.valid && fl_req.op == store_pkg::FOP_ERASE)
      else $error("erase never reached flash");
   a_req_held: assert property (fl_req.valid && !fl_rsp.ack |=> $stable(fl_req))
      else $error("flash request dropped early");
   a_idle_no_prog: assert property (fl_req.valid && fl_req.op != store_pkg::FOP_READ |-> !pready)
      else $error("flash changed outside a command");
   a_gap_refused: assert property (tk && paddr >= store_pkg::OFF_VAR_END && paddr < store_pkg::OFF_CMD
      |-> pslverr && prdata == 32'h0)
      else $error("access past capacity accepted");
   a_status_rsvd: assert property (tk && !pwrite && paddr == store_pkg::OFF_STATUS |-> prdata[31:3] == 29'h0)
      else $error("reserved status bits set");
endmodule : store_monitor

// ==== dv/tb_persistent_variable_store.sv ====
// testbench: apb master, random variables, commit, erase, reload, corruption
// assumes flash_model as the array and store_monitor bound to the design
`timescale 1ns/1ps
module tb_persistent_variable_store;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, slow, fail, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r, sum;
   logic [3:0]  pstrb;
   logic [31:0] exp_v [40];  // values the variables should hold
   store_pkg::flash_req_t fl_req;
   store_pkg::flash_rsp_t fl_rsp;
   int seed = 40046, failures = 0, samples_checked = 0;
   persistent_variable_store #(.COMMIT_CYC(600), .ERASE_CYC(50)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .fl_req(fl_req), .fl_rsp(fl_rsp));
   flash_model fl (.clk(pclk), .slow(slow), .fail(fail), .req(fl_req), .rsp(fl_rsp));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      samples_checked++;
      if (g !== x) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, g, x);
      end
   endtask : chk
   // pready is taken at the rising edge, before that edge's updates land;
   // only the watchdog ends a wait that never completes
   task automatic idle;
      do @(posedge pclk); while (pready !== 1'b1);
   endtask : idle
   // request held until the edge that sees pready high, released after it
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      idle();
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(r, x);
   endtask : rd
   // no drive runs beside this bench, so commands are always legal
   // three commits in all, far below the endurance limit
   task automatic cmd(input logic [31:0] c);
      slow <= 1'($random(seed));
      apb(1'b1, store_pkg::OFF_CMD, c);
      idle();
   endtask : cmd
   task automatic rst;
      presetn <= 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      idle();
   endtask : rst
   // ends a hang well beyond the few thousand cycles the run needs
   initial begin
      #1000000;
      failures++;
      finish_test();
   end
   initial begin
      psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0; pstrb = 4'hf;
      slow = 0; fail = 0; presetn = 0;
      rst();
      rd(store_pkg::OFF_STATUS, 32'h1);
      rd(12'h09c, 32'h0);
      for (int i = 0; i < 40; i++) begin
         exp_v[i] = $random(seed);
         apb(1'b1, 12'(i * 4), exp_v[i]);
      end
      // byte lanes: only the low half of slot 5 takes the new data
      pstrb <= 4'h3;
      apb(1'b1, 12'h014, ~exp_v[5]);
      pstrb <= 4'hf;
      exp_v[5][15:0] = ~exp_v[5][15:0];
      chk(fl.mem[0], 32'hffff_ffff);
      rd(12'h014, exp_v[5]);
      apb(1'b1, store_pkg::OFF_IRQ_MASK, 32'h2);
      chk({31'h0, irq}, 32'h0);
      cmd(32'h1);
      rd(store_pkg::OFF_RESULT, 32'h0);
      rd(store_pkg::OFF_COUNT, 32'h1);
      rd(store_pkg::OFF_STATUS, 32'h0);
      chk({31'h0, irq}, 32'h1);
      apb(1'b0, store_pkg::OFF_IRQ_STAT, 32'h0);
      chk(r & 32'h2, 32'h2);
      chk({31'h0, irq}, 32'h0);
      sum = 32'h1;
      for (int i = 0; i < 40; i++) begin
         chk(fl.mem[i], exp_v[i]);
         sum += exp_v[i];
      end
      chk(fl.mem[40], sum);
      chk(fl.mem[41], 32'h1);
      apb(1'b0, 12'h0a0, 32'h0);
      chk({31'h0, e}, 32'h1);
      rst();
      for (int i = 0; i < 40; i++) rd(12'(i * 4), exp_v[i]);
      fail <= 1'b1;
      cmd(32'h1);
      fail <= 1'b0;
      rd(store_pkg::OFF_RESULT, 32'h1);
      rd(store_pkg::OFF_STATUS, 32'h4);
      cmd(32'h2);
      rd(store_pkg::OFF_RESULT, 32'h0);
      // the failed commit stays reported across the erase
      rd(store_pkg::OFF_STATUS, 32'h5);
      rd(store_pkg::OFF_COUNT, 32'h0);
      rd(12'h01c, exp_v[7]);
      chk(fl.mem[42], 32'hffff_ffff);
      cmd(32'h1);
      fl.mem[3] = ~fl.mem[3];
      rst();
      rd(store_pkg::OFF_STATUS, 32'h2);
      rd(12'h00c, 32'h0);
      finish_test();
   end
endmodule : tb_persistent_variable_store
bind persistent_variable_store store_monitor #(.COMMIT_CYC(600), .ERASE_CYC(50)) mon (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .irq(irq), .fl_req(fl_req), .fl_rsp(fl_rsp));

// ==== include/store_pkg.sv ====
//
// Functional notes
// - store holds 160 bytes of variables
// - init loads last committed values
// - empty store leaves variables at zero
// - invalid store loads nothing at init
// - variable writes stay volatile until commit
// - commit stores all; bit0 0=ok 1=fail
// - erase clears area; bit0 0=ok 1=fail
// - erase leaves live variables untouched
// - 32-bit commit count, cleared by erase
// - status bit0 set when never written/erased
// - status bit1 set on checksum mismatch
// - status bit2 failed write; 3..31 reserved
// - commit and erase block all other service
// - commit finishes within 8.6 ms
// - erase takes 7.0 ms, leaves all ones
// - stored entry feeds its matching variable
//
// holds register map, flash layout, timing counts and carrier types
// assumes a 25 MHz bus clock and a flash port on the same clock

package store_pkg;

   // ***************************************************************
   // storage layout
   // ***************************************************************
   localparam int          VAR_BYTES   = 160;            // user capacity
   localparam int          VAR_WORDS   = VAR_BYTES / 4;  // one slot per word
   localparam logic [5:0]  WORD_LAST_V = 6'h27;          // last variable slot
   localparam logic [5:0]  WORD_SUM    = 6'h28;          // checksum word
   localparam logic [5:0]  WORD_CNT    = 6'h29;          // commit count word
   localparam logic [5:0]  WORD_MARK   = 6'h2a;          // validity marker word
   localparam logic [31:0] ERASED_WORD = 32'hffff_ffff;  // erased flash content
   localparam logic [31:0] MARK_VALUE  = 32'h5a5a_c3c3;  // arbitrary value

   // ***************************************************************
   // register map (byte addresses)
   // ***************************************************************
   localparam int          ADDR_W       = 12;
   localparam logic [11:0] OFF_VAR_END  = 12'h0a0;  // variables at 0x000..0x09c
   localparam logic [11:0] OFF_CMD      = 12'h100;
   localparam logic [11:0] OFF_RESULT   = 12'h104;
   localparam logic [11:0] OFF_COUNT    = 12'h108;
   localparam logic [11:0] OFF_STATUS   = 12'h10c;
   localparam logic [11:0] OFF_IRQ_STAT = 12'h110;
   localparam logic [11:0] OFF_IRQ_MASK = 12'h114;

   // field positions
   localparam int CMD_COMMIT_BIT = 0;
   localparam int CMD_ERASE_BIT  = 1;
   localparam int ST_EMPTY_BIT   = 0;
   localparam int ST_CORRUPT_BIT = 1;
   localparam int ST_WERR_BIT    = 2;
   localparam int IRQ_INIT_BIT   = 0;
   localparam int IRQ_COMMIT_BIT = 1;
   localparam int IRQ_ERASE_BIT  = 2;
   localparam int IRQ_FAIL_BIT   = 3;
   localparam int IRQ_W          = 4;

   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int CLK_NS        = 40;
   localparam int COMMIT_MAX_NS = 8_600_000;
   localparam int ERASE_NS      = 7_000_000;
   localparam int COMMIT_CYC    = COMMIT_MAX_NS / CLK_NS;             // longest: round down
   localparam int ERASE_CYC     = (ERASE_NS + CLK_NS - 1) / CLK_NS;   // least: round up
   localparam int TMR_W         = 18;

   // ***************************************************************
   // types
   // ***************************************************************
   typedef enum logic [1:0] {FOP_READ, FOP_WRITE, FOP_ERASE} flash_op_t;

   typedef struct packed {
      logic        valid;   // held until ack or the time limit
      flash_op_t   op;
      logic [5:0]  addr;    // word index in the area
      logic [31:0] wdata;
   } flash_req_t;

   typedef struct packed {
      logic        ack;     // one-cycle completion
      logic        err;     // operation failed
      logic [31:0] rdata;
   } flash_rsp_t;

   typedef enum logic [2:0] {
      ST_LOAD_CHK, ST_LOAD_CPY, ST_IDLE, ST_COMMIT, ST_ERASE
   } state_t;

endpackage : store_pkg

// ==== logic/persistent_variable_store.sv ====
//
// persistent variable store: live variables, commit/erase engine, apb slave
// assumes an apb4 master on pclk and a flash port answering on pclk
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps

module persistent_variable_store #(
   parameter int COMMIT_CYC = store_pkg::COMMIT_CYC,  // commit time limit
   parameter int ERASE_CYC  = store_pkg::ERASE_CYC    // erase duration
) (
   // clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // apb slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   input  wire logic [3:0]            pstrb,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // interrupt
   output logic                       irq,
   // flash array port
   output store_pkg::flash_req_t      fl_req,
   input  wire store_pkg::flash_rsp_t fl_rsp
);

   // ***************************************************************
   // state
   // ***************************************************************
   store_pkg::state_t state_ff,   nxt_state;    // engine state
   logic [5:0]        idx_ff,     nxt_idx;      // current word index
   logic [31:0]       sum_ff,     nxt_sum;      // running checksum
   logic [31:0]       chk_ff,     nxt_chk;      // checksum read back
   logic [store_pkg::TMR_W-1:0] tmr_ff, nxt_tmr; // operation timer
   store_pkg::flash_req_t req_ff, nxt_req;      // outstanding flash op
   logic              res_ff,     nxt_res;      // last command result
   logic [31:0]       cnt_ff,     nxt_cnt;      // commit count, cleared by erase
   logic              empty_ff,   nxt_empty;    // store_empty_flag
   logic              corrupt_ff, nxt_corrupt;  // contents_corrupt_flag
   logic              werr_ff,    nxt_werr;     // commit_failed_flag
   logic              edone_ff,   nxt_edone;    // erase acknowledged
   logic              eerr_ff,    nxt_eerr;     // erase reported error
   logic [31:0]       vars_ff  [store_pkg::VAR_WORDS];  // live variables
   logic [31:0]       nxt_vars [store_pkg::VAR_WORDS];

   // events into the interrupt status
   logic ev_init, ev_commit, ev_erase, ev_fail;

   // bus side
   logic [31:0]            prdata_ff, nxt_prdata;  // read data
   logic [store_pkg::IRQ_W-1:0] istat_ff, nxt_istat; // sticky events
   logic [store_pkg::IRQ_W-1:0] imask_ff, nxt_imask; // enables
   logic                   irq_ff,    nxt_irq;       // registered line

   // decode
   logic        access;      // access phase completes this edge
   logic        wr_acc;      // completed write
   logic        rd_acc;      // completed read
   logic        hit_var;     // variable window
   logic        hit_reg;     // any mapped register
   logic [5:0]  widx;        // variable slot from address
   logic [31:0] rd_val;      // read mux
   logic        cmd_commit;  // commit requested
   logic        cmd_erase;   // erase requested
   logic        rsp_ok;      // ack for the outstanding op
   logic [31:0] cnt_inc;     // count after this commit

   // ***************************************************************
   // apb decode
   // ***************************************************************

   // the bus stalls whenever the engine works, so nothing else is
   // serviced during load, commit or erase
   assign pready  = (state_ff == store_pkg::ST_IDLE);
   assign access  = psel & penable & pready;
   assign wr_acc  = access & pwrite;
   assign rd_acc  = access & ~pwrite;
   assign widx    = paddr[7:2];
   assign hit_var = (paddr < store_pkg::OFF_VAR_END) && (paddr[1:0] == 2'b00);
   assign hit_reg = hit_var
                  || (paddr == store_pkg::OFF_CMD)
                  || (paddr == store_pkg::OFF_RESULT)
                  || (paddr == store_pkg::OFF_COUNT)
                  || (paddr == store_pkg::OFF_STATUS)
                  || (paddr == store_pkg::OFF_IRQ_STAT)
                  || (paddr == store_pkg::OFF_IRQ_MASK);
   assign pslverr = access & ~hit_reg;   // unmapped or unaligned
   assign prdata  = prdata_ff;
   assign irq     = irq_ff;
   assign fl_req  = req_ff;

   // commit wins if software sets both bits at once
   assign cmd_commit = wr_acc && (paddr == store_pkg::OFF_CMD)
                       && pwdata[store_pkg::CMD_COMMIT_BIT];
   assign cmd_erase  = wr_acc && (paddr == store_pkg::OFF_CMD)
                       && pwdata[store_pkg::CMD_ERASE_BIT] && !cmd_commit;
   assign rsp_ok     = fl_rsp.ack & req_ff.valid;
   assign cnt_inc    = cnt_ff + 32'h0000_0001;

   // read mux, reserved bits read as zero
   always_comb begin
      rd_val = 32'h0000_0000;
      if (hit_var) begin
         rd_val = vars_ff[widx];
      end else begin
         case (paddr)
            store_pkg::OFF_RESULT:   rd_val[0] = res_ff;
            store_pkg::OFF_COUNT:    rd_val = cnt_ff;
            store_pkg::OFF_STATUS: begin
               rd_val[store_pkg::ST_EMPTY_BIT]   = empty_ff;
               rd_val[store_pkg::ST_CORRUPT_BIT] = corrupt_ff;
               rd_val[store_pkg::ST_WERR_BIT]    = werr_ff;
            end
            store_pkg::OFF_IRQ_STAT: rd_val[store_pkg::IRQ_W-1:0] = istat_ff;
            store_pkg::OFF_IRQ_MASK: rd_val[store_pkg::IRQ_W-1:0] = imask_ff;
            default:                 rd_val = 32'h0000_0000;
         endcase
      end
   end

   // ***************************************************************
   // bus registers and interrupts
   // ***************************************************************

   // read data is sampled every cycle the slave is selected, so the
   // access phase returns what was captured one edge earlier
   always_comb begin
      nxt_prdata = psel ? rd_val : prdata_ff;
      nxt_imask  = imask_ff;
      nxt_istat  = istat_ff;
      if (wr_acc && (paddr == store_pkg::OFF_IRQ_MASK)) begin
         nxt_imask = pwdata[store_pkg::IRQ_W-1:0];
      end
      // read clears only what was returned; a new event wins
      if (rd_acc && (paddr == store_pkg::OFF_IRQ_STAT)) begin
         nxt_istat = istat_ff & ~prdata_ff[store_pkg::IRQ_W-1:0];
      end
      nxt_istat[store_pkg::IRQ_INIT_BIT]   = nxt_istat[store_pkg::IRQ_INIT_BIT]   | ev_init;
      nxt_istat[store_pkg::IRQ_COMMIT_BIT] = nxt_istat[store_pkg::IRQ_COMMIT_BIT] | ev_commit;
      nxt_istat[store_pkg::IRQ_ERASE_BIT]  = nxt_istat[store_pkg::IRQ_ERASE_BIT]  | ev_erase;
      nxt_istat[store_pkg::IRQ_FAIL_BIT]   = nxt_istat[store_pkg::IRQ_FAIL_BIT]   | ev_fail;
      nxt_irq    = |(nxt_istat & nxt_imask);
   end

   // bus side registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
         istat_ff  <= '0;
         imask_ff  <= '0;
         irq_ff    <= 1'b0;
      end else begin
         prdata_ff <= nxt_prdata;
         istat_ff  <= nxt_istat;
         imask_ff  <= nxt_imask;
         irq_ff    <= nxt_irq;
      end
   end

   // ***************************************************************
   // engine: load, commit, erase
   // ***************************************************************

   // one flash word at a time; a request is raised only when none is
   // outstanding, which costs a cycle per word but keeps ack pairing simple
   always_comb begin
      nxt_state   = state_ff;
      nxt_idx     = idx_ff;
      nxt_sum     = sum_ff;
      nxt_chk     = chk_ff;
      nxt_tmr     = tmr_ff;
      nxt_req     = req_ff;
      nxt_res     = res_ff;
      nxt_cnt     = cnt_ff;
      nxt_empty   = empty_ff;
      nxt_corrupt = corrupt_ff;
      nxt_werr    = werr_ff;
      nxt_edone   = edone_ff;
      nxt_eerr    = eerr_ff;
      nxt_vars    = vars_ff;
      ev_init     = 1'b0;
      ev_commit   = 1'b0;
      ev_erase    = 1'b0;
      ev_fail     = 1'b0;
      if (rsp_ok) begin
         nxt_req.valid = 1'b0;
      end
      // software writes land only in the live copy
      if (wr_acc && hit_var) begin
         for (int b = 0; b < 4; b++) begin
            if (pstrb[b]) begin
               nxt_vars[widx][8*b +: 8] = pwdata[8*b +: 8];
            end
         end
      end
      case (state_ff)
         // first pass: validate without touching the variables
         store_pkg::ST_LOAD_CHK: begin
            if (!req_ff.valid) begin
               nxt_req = '{valid: 1'b1, op: store_pkg::FOP_READ, addr: idx_ff,
                           wdata: 32'h0000_0000};
            end else if (rsp_ok) begin
               nxt_idx = idx_ff + 6'h01;
               if (idx_ff <= store_pkg::WORD_LAST_V) begin
                  nxt_sum = sum_ff + fl_rsp.rdata;
               end else if (idx_ff == store_pkg::WORD_SUM) begin
                  nxt_chk = fl_rsp.rdata;
               end else if (idx_ff == store_pkg::WORD_CNT) begin
                  nxt_sum = sum_ff + fl_rsp.rdata;
                  nxt_cnt = fl_rsp.rdata;
               end else begin
                  nxt_idx = 6'h00;
                  if (fl_rsp.rdata == store_pkg::ERASED_WORD) begin
                     // blank area: variables keep their zero reset
                     nxt_empty = 1'b1;
                     nxt_cnt   = 32'h0000_0000;
                     nxt_state = store_pkg::ST_IDLE;
                     ev_init   = 1'b1;
                  end else if ((fl_rsp.rdata != store_pkg::MARK_VALUE)
                               || (sum_ff != chk_ff)) begin
                     // nothing is copied from a bad image
                     nxt_corrupt = 1'b1;
                     nxt_cnt     = 32'h0000_0000;
                     nxt_state   = store_pkg::ST_IDLE;
                     ev_init     = 1'b1;
                  end else begin
                     nxt_state = store_pkg::ST_LOAD_CPY;
                  end
               end
            end
         end
         // second pass: copy each slot into its own variable
         store_pkg::ST_LOAD_CPY: begin
            if (!req_ff.valid) begin
               nxt_req = '{valid: 1'b1, op: store_pkg::FOP_READ, addr: idx_ff,
                           wdata: 32'h0000_0000};
            end else if (rsp_ok) begin
               nxt_vars[idx_ff] = fl_rsp.rdata;
               nxt_idx          = idx_ff + 6'h01;
               if (idx_ff == store_pkg::WORD_LAST_V) begin
                  nxt_idx   = 6'h00;
                  nxt_state = store_pkg::ST_IDLE;
                  ev_init   = 1'b1;
               end
            end
         end
         // waiting for software
         store_pkg::ST_IDLE: begin
            if (cmd_commit) begin
               nxt_state = store_pkg::ST_COMMIT;
               nxt_idx   = 6'h00;
               nxt_sum   = 32'h0000_0000;
               nxt_tmr   = '0;
            end else if (cmd_erase) begin
               nxt_state = store_pkg::ST_ERASE;
               nxt_tmr   = '0;
               nxt_edone = 1'b0;
               nxt_eerr  = 1'b0;
               nxt_req   = '{valid: 1'b1, op: store_pkg::FOP_ERASE, addr: 6'h00,
                             wdata: 32'h0000_0000};
            end
         end
         // write every slot, then checksum, count and marker
         store_pkg::ST_COMMIT: begin
            nxt_tmr = tmr_ff + 1'b1;
            if (tmr_ff == store_pkg::TMR_W'(COMMIT_CYC - 1)) begin
               // out of time: abandon and report
               nxt_req.valid = 1'b0;
               nxt_res       = 1'b1;
               nxt_werr      = 1'b1;
               nxt_idx       = 6'h00;
               nxt_state     = store_pkg::ST_IDLE;
               ev_commit     = 1'b1;
               ev_fail       = 1'b1;
            end else if (!req_ff.valid) begin
               nxt_req.valid = 1'b1;
               nxt_req.op    = store_pkg::FOP_WRITE;
               nxt_req.addr  = idx_ff;
               if (idx_ff <= store_pkg::WORD_LAST_V) begin
                  nxt_req.wdata = vars_ff[idx_ff];
               end else if (idx_ff == store_pkg::WORD_SUM) begin
                  nxt_req.wdata = sum_ff + cnt_inc;
               end else if (idx_ff == store_pkg::WORD_CNT) begin
                  nxt_req.wdata = cnt_inc;
               end else begin
                  nxt_req.wdata = store_pkg::MARK_VALUE;
               end
            end else if (rsp_ok) begin
               nxt_idx = idx_ff + 6'h01;
               if (fl_rsp.err) begin
                  nxt_res   = 1'b1;
                  nxt_werr  = 1'b1;
                  nxt_idx   = 6'h00;
                  nxt_state = store_pkg::ST_IDLE;
                  ev_commit = 1'b1;
                  ev_fail   = 1'b1;
               end else if (idx_ff <= store_pkg::WORD_LAST_V) begin
                  nxt_sum = sum_ff + vars_ff[idx_ff];
               end else if (idx_ff == store_pkg::WORD_MARK) begin
                  nxt_cnt     = cnt_inc;
                  nxt_res     = 1'b0;
                  nxt_empty   = 1'b0;
                  nxt_corrupt = 1'b0;
                  nxt_werr    = 1'b0;
                  nxt_idx     = 6'h00;
                  nxt_state   = store_pkg::ST_IDLE;
                  ev_commit   = 1'b1;
               end
            end
         end
         // erase runs its full time; variables are left alone
         store_pkg::ST_ERASE: begin
            nxt_tmr = tmr_ff + 1'b1;
            if (rsp_ok) begin
               nxt_edone = 1'b1;
               nxt_eerr  = fl_rsp.err;
            end
            if (tmr_ff == store_pkg::TMR_W'(ERASE_CYC - 1)) begin
               nxt_req.valid = 1'b0;
               nxt_state     = store_pkg::ST_IDLE;
               ev_erase      = 1'b1;
               if (nxt_edone && !nxt_eerr) begin
                  nxt_res     = 1'b0;
                  nxt_empty   = 1'b1;
                  nxt_corrupt = 1'b0;
                  nxt_cnt     = 32'h0000_0000;
               end else begin
                  nxt_res = 1'b1;
                  ev_fail = 1'b1;
               end
            end
         end
         default: begin
            nxt_state = store_pkg::ST_IDLE;
         end
      endcase
   end

   // engine registers; load starts on reset release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff   <= store_pkg::ST_LOAD_CHK;
         idx_ff     <= 6'h00;
         sum_ff     <= 32'h0000_0000;
         chk_ff     <= 32'h0000_0000;
         tmr_ff     <= '0;
         req_ff     <= '0;
         res_ff     <= 1'b0;
         cnt_ff     <= 32'h0000_0000;
         empty_ff   <= 1'b0;
         corrupt_ff <= 1'b0;
         werr_ff    <= 1'b0;
         edone_ff   <= 1'b0;
         eerr_ff    <= 1'b0;
         for (int i = 0; i < store_pkg::VAR_WORDS; i++) begin
            vars_ff[i] <= 32'h0000_0000;
         end
      end else begin
         state_ff   <= nxt_state;
         idx_ff     <= nxt_idx;
         sum_ff     <= nxt_sum;
         chk_ff     <= nxt_chk;
         tmr_ff     <= nxt_tmr;
         req_ff     <= nxt_req;
         res_ff     <= nxt_res;
         cnt_ff     <= nxt_cnt;
         empty_ff   <= nxt_empty;
         corrupt_ff <= nxt_corrupt;
         werr_ff    <= nxt_werr;
         edone_ff   <= nxt_edone;
         eerr_ff    <= nxt_eerr;
         vars_ff    <= nxt_vars;
      end
   end

endmodule : persistent_variable_store
